// ===== design/nvmac_top.sv
/*
 * nonvolatile array control: 2 Kbyte flop array with control register,
 * block protection, erase blocks, byte program, margin bit, security.
 * assumes a synchronous bus master on CORE_CLK; read data one cycle late.
 */
// Implementation choice: the strobed register port.
// Operation
// - array holds 2031 user bytes, 14 vector bytes, one protect byte
// - erased bits read 0, programmed bits read 1
// - control register at its fixed address governs program, erase, margin
// - top locations FFF2 to FFFF hold user vectors
// - last user byte is reserved clock-generator trim storage
// - user space is 8-byte rows, row 0 at 7800, row 253 last
// - each program operation writes exactly one byte
// - erase acts on blocks, smallest one row of eight bytes
// - internal charge pump powers program and erase from one supply
// - pump-divide bit picks bus clock divide by one or two
// - two block bits choose erase block size
// - margin read mode checks programmed bit margin; here the margin bit is only stored and changes no read
// - security blocks viewing of array contents; here SECURE hides only user bytes 7800-7FEE
// - block code 00 full, 01 half, 10 eight rows, 11 one row
// - program and erase select never set together
// - high voltage settable only with program or erase and sequence
// - margin bit cannot be set while high voltage enabled
`timescale 1ns/1ns
`include "nvmac_defs.svh"
module nvmac_top #(
   parameter int HV_CYCLES = `NVMAC_HV_CYC
) (
   // clock and reset
   input  wire logic                 CORE_CLK,
   input  wire logic                 RST_N,
   // register and array bus
   input  wire nvmac_pkg::nvmac_addr_t ADDR,
   input  wire nvmac_pkg::nvmac_byte_t WDATA,
   input  wire logic                 WR,
   input  wire logic                 RD,
   output logic [7:0]                RDATA,
   // security and status
   input  wire logic                 SECURE,
   output logic                      PUMP_ON,
   output logic                      HV_BUSY
);
   import nvmac_pkg::*;

   localparam int AW = 11;

   // refuse settings that the timer or the array index cannot serve
   if (HV_CYCLES < 1 || HV_CYCLES > 65535) begin : g_bad_cycles
      $error("HV_CYCLES out of range");
   end
   if ((1 << AW) != `NVMAC_ARRAY_BYTES) begin : g_bad_width
      $error("array index width does not match array size");
   end

   // registered state and next values
   logic       rst_m;
   logic       rst_n;
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [7:0] mem [`NVMAC_ARRAY_BYTES];
   logic [7:0] next_rdata;
   logic [3:0] bpr;
   logic [3:0] next_bpr;
   logic       bpr_seen;
   logic       next_bpr_seen;
   logic [AW-1:0] lat_addr;
   logic [AW-1:0] next_lat_addr;
   logic [7:0] lat_data;
   logic [7:0] next_lat_data;
   logic       latched;
   logic       next_latched;
   nvmac_hv_t  hv;
   nvmac_hv_t  next_hv;
   logic [15:0] hv_cnt;
   logic [15:0] next_hv_cnt;
   logic       pump_on;
   logic       hv_busy;

   nvmac_pump_if pif ();

   // reset release through two flops
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   nvmac_pump u_pump (
      .clk   (CORE_CLK),
      .rst_n (rst_n),
      .pif   (pif)
   );

   // array address space decode
   function automatic logic in_array(input logic [15:0] a);
      in_array = (a >= `NVMAC_USER_LO && a <= `NVMAC_TRIM_ADDR) ||
                 (a >= `NVMAC_BPR_ADDR && a <= `NVMAC_VEC_HI);
   endfunction

   // user region map: 7800-7FEF low, FFF0-FFFF folded to top 16 bytes
   function automatic logic [AW-1:0] idx(input logic [15:0] a);
      idx = a[AW-1:0];
   endfunction

   function automatic logic [AW-1:0] blk_mask(input logic [1:0] b);
      case (b)
         `NVMAC_BLK_FULL:  blk_mask = `NVMAC_MASK_FULL;
         `NVMAC_BLK_HALF:  blk_mask = `NVMAC_MASK_HALF;
         `NVMAC_BLK_EIGHT: blk_mask = `NVMAC_MASK_EIGHT;
         default:          blk_mask = `NVMAC_MASK_ROW;
      endcase
   endfunction

   // bus decode and erase block
   logic [1:0]    blk;
   logic [AW-1:0] emask;
   logic          ctrl_wr;
   logic          arr_wr;
   logic          arr_rd;

   always_comb begin
      blk     = {ctrl[`NVMAC_BIT_BLK_HI], ctrl[`NVMAC_BIT_BLK_LO]};
      emask   = blk_mask(blk);
      ctrl_wr = WR && ADDR == `NVMAC_CTRL_ADDR;
      arr_wr  = WR && in_array(ADDR);
      arr_rd  = RD && in_array(ADDR);
   end

   // protection: each protect bit guards from its boundary to the top;
   // an erase is judged by the last byte of the block it removes
   localparam logic [AW-1:0] PROT_LO [4] = '{
      `NVMAC_PROT0_LO,
      `NVMAC_PROT1_LO,
      `NVMAC_PROT2_LO,
      `NVMAC_PROT3_LO
   };
   logic [3:0]    prot_bit;
   logic [AW-1:0] prot_end;
   logic          prot_hit;

   always_comb begin
      prot_end = lat_addr | (ctrl[`NVMAC_BIT_ERASE] ? ~emask : {AW{1'b0}});
      prot_hit = bpr_seen && latched && (|prot_bit);
   end

   genvar p;
   generate
      for (p = 0; p < $bits(bpr); p++) begin : g_prot
         assign prot_bit[p] = bpr[p] && (prot_end >= PROT_LO[p]);
      end
   endgenerate

   // control register and operation sequencing
   always_comb begin
      next_ctrl     = ctrl;
      next_bpr      = bpr;
      next_bpr_seen = bpr_seen;
      next_lat_addr = lat_addr;
      next_lat_data = lat_data;
      next_latched  = latched;
      if (ctrl_wr) begin
         next_ctrl = WDATA & `NVMAC_CTRL_MASK;
         // a write selecting both keeps whichever was already set
         if (WDATA[`NVMAC_BIT_PGM] && WDATA[`NVMAC_BIT_ERASE]) begin
            next_ctrl[`NVMAC_BIT_PGM]   = ctrl[`NVMAC_BIT_PGM];
            next_ctrl[`NVMAC_BIT_ERASE] = ctrl[`NVMAC_BIT_ERASE];
         end
         if (next_ctrl[`NVMAC_BIT_PGM] && next_ctrl[`NVMAC_BIT_ERASE])
            next_ctrl[`NVMAC_BIT_ERASE] = 1'b0;
         // high voltage needs a selected op, protect read and latched target
         if (!(next_ctrl[`NVMAC_BIT_PGM] || next_ctrl[`NVMAC_BIT_ERASE]) ||
             !bpr_seen || !latched)
            next_ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE] = 1'b0;
         if (next_ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE] || ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE])
            next_ctrl[`NVMAC_BIT_MARGIN] = 1'b0;
         if (!next_ctrl[`NVMAC_BIT_PGM] && !next_ctrl[`NVMAC_BIT_ERASE]) begin
            next_bpr_seen = 1'b0;
            next_latched  = 1'b0;
         end
      end
      if (arr_rd && ADDR == `NVMAC_BPR_ADDR &&
          (ctrl[`NVMAC_BIT_PGM] || ctrl[`NVMAC_BIT_ERASE])) begin
         next_bpr      = mem[idx(ADDR)][3:0];
         next_bpr_seen = 1'b1;
      end
      if (arr_wr && (ctrl[`NVMAC_BIT_PGM] || ctrl[`NVMAC_BIT_ERASE]) &&
          !ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE]) begin
         next_lat_addr = idx(ADDR);
         next_lat_data = WDATA;
         next_latched  = 1'b1;
      end
      // protected target drops the select bit so no high voltage follows
      if (prot_hit && !ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE]) begin
         next_ctrl[`NVMAC_BIT_PGM]   = 1'b0;
         next_ctrl[`NVMAC_BIT_ERASE] = 1'b0;
         next_ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE]  = 1'b0;
      end
   end

   // high voltage step timer, paced by pump ticks
   always_comb begin
      next_hv     = hv;
      next_hv_cnt = hv_cnt;
      case (hv)
         NVMAC_IDLE: begin
            if (ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE] && pif.tick) begin
               next_hv     = ctrl[`NVMAC_BIT_PGM] ? NVMAC_PROG : NVMAC_ERASE;
               next_hv_cnt = 16'(HV_CYCLES);
            end
         end
         NVMAC_PROG, NVMAC_ERASE: begin
            if (!ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE])
               next_hv = NVMAC_IDLE;
            else if (pif.tick && hv_cnt != 16'h0000)
               next_hv_cnt = hv_cnt - 16'h0001;
         end
         default: next_hv = NVMAC_IDLE;
      endcase
   end

   // pump runs only while high voltage is enabled
   always_comb begin
      pif.run  = ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE];
      pif.div2 = ctrl[`NVMAC_BIT_FDIV];
   end

   // array read: secure hides user bytes only; trim, protect bytes and vectors stay readable
   always_comb begin
      next_rdata = 8'h00;
      if (RD && ADDR == `NVMAC_CTRL_ADDR)
         next_rdata = ctrl;
      else if (arr_rd) begin
         if (SECURE && ADDR >= `NVMAC_USER_LO &&
             ADDR < `NVMAC_TRIM_ADDR)
            next_rdata = `NVMAC_SECURE_BYTE;
         else
            next_rdata = mem[idx(ADDR)];
      end
   end

   // array cells: erase to zero, program ors ones in
   genvar g;
   generate
      for (g = 0; g < `NVMAC_ARRAY_BYTES; g++) begin : g_cell
         logic [7:0] next_cell;
         always_comb begin
            next_cell = mem[g];
            if (hv == NVMAC_ERASE && hv_cnt == 16'h0001 && pif.tick &&
                ((AW'(g) & emask) == (lat_addr & emask)))
               next_cell = `NVMAC_ERASED_BYTE;
            else if (hv == NVMAC_PROG && hv_cnt == 16'h0001 && pif.tick &&
                     lat_addr == AW'(g))
               next_cell = mem[g] | lat_data;
         end
         always_ff @(posedge CORE_CLK or negedge rst_n) begin
            if (!rst_n)
               mem[g] <= `NVMAC_ERASED_BYTE;
            else
               mem[g] <= next_cell;
         end
      end
   endgenerate

   // busy covers the timed part of a pulse only; the pump stays on
   // until software clears high voltage enable
   always_comb begin
      pump_on = ctrl[`NVMAC_BIT_HIGH_VOLTAGE_ENABLE];
      hv_busy = (next_hv != NVMAC_IDLE) && (next_hv_cnt != 16'h0000);
   end

   // state and output registers
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= `NVMAC_CTRL_RESET;
         bpr      <= 4'h0;
         bpr_seen <= 1'b0;
         lat_addr <= '0;
         lat_data <= 8'h00;
         latched  <= 1'b0;
         hv       <= NVMAC_IDLE;
         hv_cnt   <= 16'h0000;
         RDATA    <= 8'h00;
         PUMP_ON  <= 1'b0;
         HV_BUSY  <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         bpr      <= next_bpr;
         bpr_seen <= next_bpr_seen;
         lat_addr <= next_lat_addr;
         lat_data <= next_lat_data;
         latched  <= next_latched;
         hv       <= next_hv;
         hv_cnt   <= next_hv_cnt;
         RDATA    <= next_rdata;
         PUMP_ON  <= pump_on;
         HV_BUSY  <= hv_busy;
      end
   end
endmodule

// ===== design/nvmac_defs.svh
/*
 * constants for the nonvolatile array control block: control register
 * address and field positions, array map, erase block codes, timing.
 * assumes inclusion by bare name from design files only.
 */
`ifndef NVMAC_DEFS_SVH
`define NVMAC_DEFS_SVH

`define NVMAC_CTRL_ADDR     16'hFE08
`define NVMAC_CTRL_RESET    8'h00
`define NVMAC_BIT_PGM       0
`define NVMAC_BIT_ERASE     1
`define NVMAC_BIT_MARGIN    2
`define NVMAC_BIT_HIGH_VOLTAGE_ENABLE      3
`define NVMAC_BIT_BLK_LO    4
`define NVMAC_BIT_BLK_HI    5
`define NVMAC_BIT_FDIV      6
`define NVMAC_CTRL_MASK     8'h7F

`define NVMAC_USER_LO       16'h7800
`define NVMAC_USER_HI       16'h7FEE
`define NVMAC_TRIM_ADDR     16'h7FEF
`define NVMAC_BPR_ADDR      16'hFFF0
`define NVMAC_BPR_SPARE     16'hFFF1
`define NVMAC_VEC_LO        16'hFFF2
`define NVMAC_VEC_HI        16'hFFFF
`define NVMAC_ARRAY_BYTES   2048
`define NVMAC_LAST_ROW      8'hFD
`define NVMAC_ROW_SHIFT     3
`define NVMAC_ERASED_BYTE   8'h00
`define NVMAC_SECURE_BYTE   8'h00
`define NVMAC_PROT0_LO      11'h040
`define NVMAC_PROT1_LO      11'h080
`define NVMAC_PROT2_LO      11'h100
`define NVMAC_PROT3_LO      11'h200

`define NVMAC_BLK_FULL      2'h0
`define NVMAC_BLK_HALF      2'h1
`define NVMAC_BLK_EIGHT     2'h2
`define NVMAC_BLK_ROW       2'h3
`define NVMAC_MASK_FULL     11'h000
`define NVMAC_MASK_HALF     11'h400
`define NVMAC_MASK_EIGHT    11'h7C0
`define NVMAC_MASK_ROW      11'h7F8

`define NVMAC_HV_STEP_NS    1000
`define NVMAC_CLK_NS        100
`define NVMAC_HV_CYC        ((`NVMAC_HV_STEP_NS + `NVMAC_CLK_NS - 1) / `NVMAC_CLK_NS)

`endif

// ===== design/nvmac_pkg.sv
/*
 * types for the nonvolatile array control block.
 * assumes nvmac_defs.svh is available for inclusion.
 */
`include "nvmac_defs.svh"
package nvmac_pkg;
   typedef logic [15:0] nvmac_addr_t;
   typedef logic [7:0]  nvmac_byte_t;
   typedef enum logic [1:0] {
      NVMAC_IDLE  = 2'b00,
      NVMAC_PROG  = 2'b01,
      NVMAC_ERASE = 2'b10
   } nvmac_hv_t;
endpackage

// ===== design/nvmac_pump_if.sv
/*
 * interface between the control register logic and the charge pump
 * divider. assumes a single clock domain.
 */
`timescale 1ns/1ns
interface nvmac_pump_if;
   logic run;
   logic div2;
   logic tick;
   modport ctrl (output run, output div2, input tick);
   modport pump (input run, input div2, output tick);
endinterface

// ===== design/nvmac_pump.sv
/*
 * charge pump clock divider: one-cycle enable at bus rate or half it.
 * assumes active-low reset from the top module, asserted asynchronously and released synchronously.
 */
`timescale 1ns/1ns
module nvmac_pump (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control side
   nvmac_pump_if.pump pif
);
   logic phase;
   logic next_phase;
   logic tick;
   logic next_tick;

   always_comb begin
      next_phase = pif.run ? ~phase : 1'b0;
      next_tick  = pif.run & (~pif.div2 | phase);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 1'b0;
         tick  <= 1'b0;
      end else begin
         phase <= next_phase;
         tick  <= next_tick;
      end
   end

   assign pif.tick = tick;
endmodule

// ===== tb/nvmac_top_asserts.sv
/* checker for nvmac_top, bound to each instance.
   assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ns
module nvmac_top_asserts #(
   parameter int HV_CYCLES = 10
) (
   input wire logic                   CORE_CLK,
   input wire logic                   RST_N,
   input wire nvmac_pkg::nvmac_addr_t ADDR,
   input wire nvmac_pkg::nvmac_byte_t WDATA,
   input wire logic                   WR,
   input wire logic                   RD,
   input wire logic [7:0]             RDATA,
   input wire logic                   SECURE,
   input wire logic                   PUMP_ON,
   input wire logic                   HV_BUSY
);
   import nvmac_pkg::*;
   localparam int BUSY_MAX = 2 * HV_CYCLES + 4;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   sequence ctrl_rd;
      RD && ADDR == 16'hFE08;
   endsequence
   sequence busy_start;
      $rose(HV_BUSY);
   endsequence
   a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not zero without a read");
   a_unmapped_zero: assert property (RD && ADDR == 16'hFE09
      |=> RDATA == 8'h00) else $error("unmapped read not zero");
   a_secure_hides: assert property (RD && SECURE
      && ADDR >= 16'h7800 && ADDR <= 16'h7FEE |=> RDATA == 8'h00)
      else $error("user byte visible while secured");
   a_ctrl_top_bit: assert property (ctrl_rd |=> !RDATA[7])
      else $error("control bit 7 reads one");
   a_sel_exclusive: assert property (ctrl_rd
      |=> !(RDATA[0] && RDATA[1])) else $error("program and erase both set");
   a_margin_hv: assert property (ctrl_rd
      |=> !(RDATA[2] && RDATA[3])) else $error("margin set with high voltage");
   a_hv_needs_sel: assert property (ctrl_rd
      |=> !RDATA[3] || RDATA[1:0] != 2'h0) else $error("hv without select");
   a_busy_ends: assert property (busy_start
      |-> ##[1:BUSY_MAX] !HV_BUSY) else $error("pulse too long");
   a_busy_pump: assert property (busy_start
      |-> ##[0:2] PUMP_ON) else $error("pulse without charge pump");
endmodule
bind nvmac_top nvmac_top_asserts #(.HV_CYCLES(HV_CYCLES)) u_asserts (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .SECURE(SECURE),
   .PUMP_ON(PUMP_ON), .HV_BUSY(HV_BUSY));

// ===== tb/nvm_array_control_bench.sv
/* bench for nvmac_top: control register, program, erase, security.
   assumes the design files and the checker are compiled first. */
`timescale 1ns/1ns
module nvm_array_control_bench;
   localparam int HV = 4;
   logic                   CORE_CLK = 1'b0;
   logic                   RST_N = 1'b0;
   logic                   WR = 1'b0;
   logic                   RD = 1'b0;
   logic                   SECURE = 1'b0;
   nvmac_pkg::nvmac_addr_t ADDR = 16'h0000;
   nvmac_pkg::nvmac_byte_t WDATA = 8'h00;
   logic [7:0]             RDATA;
   logic                   PUMP_ON;
   logic                   HV_BUSY;
   int                     fail_count = 0;
   int                     checks = 0;
   always #50 CORE_CLK = ~CORE_CLK;
   nvmac_top #(.HV_CYCLES(HV)) dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .SECURE(SECURE), .PUMP_ON(PUMP_ON), .HV_BUSY(HV_BUSY));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge CORE_CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      @(negedge CORE_CLK);
      chk(RDATA, exp);
   endtask
   // select, protect read, target write, pulse, then release
   task automatic hv_op(input logic [7:0] c, input logic [15:0] a,
                        input logic [7:0] d);
      int n;
      int m;
      n = 0;
      m = c[6] ? 2 * HV : HV;
      wr(16'hFE08, c);
      rd(16'hFFF0, 8'h00);
      wr(a, d);
      wr(16'hFE08, c | 8'h08);
      repeat (40) begin
         @(negedge CORE_CLK);
         if (HV_BUSY === 1'b1) n++;
      end
      chk({7'h00, n >= m - 1 && n <= m + 2}, 8'h01);
      chk({7'h00, PUMP_ON}, 8'h01);
      wr(16'hFE08, c | 8'h0C);
      rd(16'hFE08, c | 8'h08);
      wr(16'hFE08, c);
      wr(16'hFE08, 8'h00);
   endtask
   initial begin
      #500000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      rd(16'hFE08, 8'h00);
      rd(16'h7800, 8'h00);
      rd(16'hFE09, 8'h00);
      wr(16'hFE08, 8'h03);
      rd(16'hFE08, 8'h00);
      wr(16'hFE08, 8'h08);
      rd(16'hFE08, 8'h00);
      wr(16'hFE08, 8'h04);
      rd(16'hFE08, 8'h04);
      wr(16'hFE08, 8'h00);
      hv_op(8'h01, 16'h7800, 8'h5A);
      hv_op(8'h41, 16'h7808, 8'hA5);
      hv_op(8'h01, 16'h7C00, 8'hC3);
      hv_op(8'h01, 16'hFFF2, 8'h3C);
      rd(16'h7800, 8'h5A);
      rd(16'h7801, 8'h00);
      rd(16'h7808, 8'hA5);
      @(posedge CORE_CLK) SECURE <= 1'b1;
      rd(16'h7808, 8'h00);
      @(posedge CORE_CLK) SECURE <= 1'b0;
      hv_op(8'h32, 16'h7803, 8'h00);
      rd(16'h7800, 8'h00);
      rd(16'h7808, 8'hA5);
      hv_op(8'h22, 16'h7800, 8'h00);
      rd(16'h7808, 8'h00);
      rd(16'h7C00, 8'hC3);
      hv_op(8'h12, 16'h7800, 8'h00);
      rd(16'h7C00, 8'hC3);
      rd(16'hFFF2, 8'h3C);
      hv_op(8'h02, 16'h7800, 8'h00);
      rd(16'h7C00, 8'h00);
      rd(16'hFFF2, 8'h00);
      // protect the upper blocks, then try a program inside them
      hv_op(8'h01, 16'hFFF0, 8'h08);
      wr(16'hFE08, 8'h01);
      rd(16'hFFF0, 8'h08);
      wr(16'h7C00, 8'hFF);
      wr(16'hFE08, 8'h09);
      rd(16'hFE08, 8'h00);
      chk({7'h00, PUMP_ON}, 8'h00);
      wr(16'hFE08, 8'h00);
      rd(16'h7C00, 8'h00);
      report_and_stop();
   end
endmodule
